// *** shared/bpm_defines.svh ***
// constants for the strap and pin-function select block
// assumes inclusion by bare name from the design file and the testbench
`ifndef BPM_DEFINES_SVH
`define BPM_DEFINES_SVH

// axi4-lite register byte addresses
`define BPM_ADDR_STRAP     12'h000
`define BPM_ADDR_PRIO      12'h004
`define BPM_ADDR_ARB       12'h008
`define BPM_ADDR_LED       12'h00C
`define BPM_ADDR_FUNCTAB   12'h010

// strap status field positions
`define BPM_ST_MS_LO       0
`define BPM_ST_MS_HI       1
`define BPM_ST_PWR_CLK     2
`define BPM_ST_ARB_DIS     3
`define BPM_ST_SCAN        4

// reset values
`define BPM_PRIO_RST       4'h0
`define BPM_LED_RST        1'b0
// default decode: index {hi,lo}; 2 bits per entry, entry 3 reserved
`define BPM_FUNCTAB_RST    8'hE4

`define BPM_AXI_OKAY       2'b00
`define BPM_AXI_SLVERR     2'b10

`endif

// *** shared/bpm_pkg.sv ***
// types for the strap and pin-function select block
// assumes bpm_defines.svh sits on the include path
package bpm_pkg;
  typedef enum logic [1:0] {
    BPM_FN_CLKRUN = 2'b00,
    BPM_FN_LOCK   = 2'b01,
    BPM_FN_HOTSWP = 2'b10,
    BPM_FN_NONE   = 2'b11
  } bpm_func_t;

  typedef enum logic [1:0] {
    BPM_ARB_IDLE  = 2'b00,
    BPM_ARB_GRANT = 2'b01,
    BPM_ARB_BUSY  = 2'b10
  } bpm_arb_state_t;

  typedef struct packed {
    logic [3:0] req_n;
    logic       frame_n;
    logic       irdy_n;
  } bpm_sec_bus_t;

  typedef struct packed {
    logic o;
    logic oe_n;
  } bpm_pin_drv_t;
endpackage : bpm_pkg

// *** design/bpm_strap_mux.sv ***
// strap sampling, multifunction pin select and secondary arbiter
// assumes straps static, all inputs synchronous to aclk
//
// The register addresses and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "bpm_defines.svh"

////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - mode pin is second mode strap if lo low, else power/clock strap.
// - primary multifunction pin carries exactly one selected function.
// - secondary multifunction pin carries exactly one selected function.
// - arbiter strap low enables internal arbiter over request/grant pins.
// - arbiter strap high disables internal arbiter; external arbiter grants.
// - external mode: request bit 0 is grant in, grant bit 0 request out.
// - external mode: park when granted, bus idle and nothing to initiate.
// - scan/led pin is scan while scan strap low, else led output.
// - four requests, high or low rotating group, one grant at most.
module bpm_strap_mux
  import bpm_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        mode_select_lo,
  input  wire logic        mode_shared_pin,
  input  wire logic        internal_arbiter_disable_strap,
  input  wire logic        scan_test_mode_n,
  input  wire logic        scan_out_int,
  input  wire logic        own_request,
  input  wire bpm_sec_bus_t sec_bus,
  output var  logic [3:0]  secondary_grant_n,
  output var  logic        own_grant,
  output var  logic        sec_parked,
  output var  bpm_func_t   primary_func,
  output var  bpm_func_t   secondary_func,
  output var  bpm_pin_drv_t scan_led_pin
);

  ////////////////////////////////////////////////////////////////////////
  // strap capture after reset release; straps are static
  logic       strap_ok_r;
  logic [4:0] strap_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_ok_r <= 1'b0;
      strap_r    <= 5'h10;
    end else if (!strap_ok_r) begin
      strap_ok_r <= 1'b1;
      strap_r    <= {scan_test_mode_n, internal_arbiter_disable_strap,
                     mode_select_lo & mode_shared_pin,
                     ~mode_select_lo & mode_shared_pin,
                     mode_select_lo};
    end
  end
  wire       ms_lo    = strap_r[`BPM_ST_MS_LO];
  wire       ms_hi    = strap_r[`BPM_ST_MS_HI];
  wire       ext_arb  = strap_r[`BPM_ST_ARB_DIS];
  wire       scan_off = strap_r[`BPM_ST_SCAN]; // pulled-up default

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [3:0] prio_r;
  logic       led_r;
  logic [7:0] functab_r;

  function automatic bpm_func_t tab_pick(input logic [7:0] tab,
                                         input logic [1:0] idx);
    tab_pick = bpm_func_t'(tab[{idx, 1'b0} +: 2]);
  endfunction

  wire [1:0] ms_idx = {ms_hi, ms_lo};
  wire bpm_func_t func_sel = tab_pick(functab_r, ms_idx);

  ////////////////////////////////////////////////////////////////////////
  // pin function outputs; one code drives both pins, so each gets one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      primary_func   <= BPM_FN_NONE;
      secondary_func <= BPM_FN_NONE;
      scan_led_pin   <= '{o: 1'b0, oe_n: 1'b1};
    end else begin
      primary_func   <= func_sel;
      secondary_func <= func_sel;
      scan_led_pin   <= '{o: scan_off ? led_r : scan_out_int,
                          oe_n: 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // secondary arbiter
  wire       bus_idle = sec_bus.frame_n & sec_bus.irdy_n;
  wire [3:0] req      = ~sec_bus.req_n;
  wire [3:0] req_hi   = req & prio_r;
  wire [3:0] req_lo   = req & ~prio_r;
  logic [1:0] last_hi_r;
  logic [1:0] last_lo_r;
  bpm_arb_state_t arb_st_r;
  logic [1:0] gnt_idx_r;

  function automatic logic [2:0] rr_pick(input logic [3:0] r,
                                         input logic [1:0] last);
    logic [1:0] k;
    rr_pick = 3'h0;
    for (int i = 1; i <= 4; i++) begin
      k = last + 2'(i);
      if (r[k] && !rr_pick[2]) rr_pick = {1'b1, k};
    end
  endfunction

  wire [2:0] pick_hi = rr_pick(req_hi, last_hi_r);
  wire [2:0] pick_lo = rr_pick(req_lo, last_lo_r);
  wire [2:0] pick    = pick_hi[2] ? pick_hi : pick_lo;
  wire       ext_gnt = ~sec_bus.req_n[0];

  always_ff @(posedge aclk) begin
    if (!aresetn || !strap_ok_r || ext_arb) begin
      arb_st_r  <= BPM_ARB_IDLE;
      gnt_idx_r <= 2'h0;
      last_hi_r <= 2'h3;
      last_lo_r <= 2'h3;
    end else begin
      unique case (arb_st_r)
        BPM_ARB_IDLE: if (pick[2]) begin
          arb_st_r  <= BPM_ARB_GRANT;
          gnt_idx_r <= pick[1:0];
          if (pick_hi[2]) last_hi_r <= pick[1:0];
          else last_lo_r <= pick[1:0];
        end
        BPM_ARB_GRANT: if (!bus_idle) arb_st_r <= BPM_ARB_BUSY;
          else if (!req[gnt_idx_r]) arb_st_r <= BPM_ARB_IDLE;
        BPM_ARB_BUSY: if (bus_idle) arb_st_r <= BPM_ARB_IDLE;
        default: arb_st_r <= BPM_ARB_IDLE;
      endcase
    end
  end

  wire [3:0] int_gnt_n = (arb_st_r == BPM_ARB_GRANT)
                         ? ~(4'h1 << gnt_idx_r) : 4'hF;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      secondary_grant_n <= 4'hF;
      own_grant         <= 1'b0;
      sec_parked        <= 1'b0;
    end else if (ext_arb) begin
      secondary_grant_n <= {3'h7, ~own_request};
      own_grant         <= ext_gnt;
      sec_parked        <= ext_gnt & bus_idle & ~own_request;
    end else begin
      secondary_grant_n <= int_gnt_n;
      own_grant         <= 1'b0;
      sec_parked        <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite slave; write takes address and data in either order
  logic        aw_got_r, w_got_r;
  logic [11:0] aw_r;
  logic [31:0] w_r;
  wire  [11:0] wa = aw_r;
  wire         wr_go = aw_got_r & w_got_r & ~s_axi_bvalid;
  wire         aw_hs = s_axi_awvalid & s_axi_awready;
  wire         w_hs  = s_axi_wvalid & s_axi_wready;
  wire         aw_got_nxt = ~wr_go & (aw_got_r | aw_hs);
  wire         w_got_nxt  = ~wr_go & (w_got_r | w_hs);
  wire         bvalid_nxt = wr_go | (s_axi_bvalid & ~s_axi_bready);
  wire         wmap = (wa == `BPM_ADDR_PRIO) || (wa == `BPM_ADDR_LED) ||
                      (wa == `BPM_ADDR_FUNCTAB);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      aw_r     <= 12'h000;
      w_r      <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `BPM_AXI_OKAY;
      prio_r    <= `BPM_PRIO_RST;
      led_r     <= `BPM_LED_RST;
      functab_r <= `BPM_FUNCTAB_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        aw_r     <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        w_r     <= s_axi_wdata;
      end
      if (wr_go) begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wmap ? `BPM_AXI_OKAY : `BPM_AXI_SLVERR;
        if (wa == `BPM_ADDR_PRIO)    prio_r    <= w_r[3:0];
        if (wa == `BPM_ADDR_LED)     led_r     <= w_r[0];
        if (wa == `BPM_ADDR_FUNCTAB) functab_r <= w_r[7:0];
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // readies are flops so every port leaves a register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
    end else begin
      s_axi_awready <= ~aw_got_nxt & ~bvalid_nxt;
      s_axi_wready  <= ~w_got_nxt & ~bvalid_nxt;
    end
  end

  wire [31:0] rd_mux =
    (s_axi_araddr == `BPM_ADDR_STRAP)   ? {27'h0, strap_r} :
    (s_axi_araddr == `BPM_ADDR_PRIO)    ? {28'h0, prio_r} :
    (s_axi_araddr == `BPM_ADDR_ARB)     ? {24'h0, own_grant, sec_parked,
                                           secondary_grant_n, arb_st_r} :
    (s_axi_araddr == `BPM_ADDR_LED)     ? {31'h0, led_r} :
    (s_axi_araddr == `BPM_ADDR_FUNCTAB) ? {24'h0, functab_r} :
                                          32'h0000_0000;
  wire rmap = (s_axi_araddr <= `BPM_ADDR_FUNCTAB) &&
              (s_axi_araddr[1:0] == 2'b00);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `BPM_AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rmap ? `BPM_AXI_OKAY : `BPM_AXI_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  wire rvalid_nxt = (s_axi_arvalid & s_axi_arready) |
                    (s_axi_rvalid & ~s_axi_rready);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
    end else begin
      s_axi_arready <= ~rvalid_nxt;
    end
  end

endmodule : bpm_strap_mux
`default_nettype wire

// *** tb/bpm_strap_mux_asserts.sv ***
// assertions on the strap mux outputs, bound to bpm_strap_mux
// assumes straps change only while aresetn is low
`timescale 1ns/1ns
`default_nettype none
module bpm_strap_mux_asserts
  import bpm_pkg::*;
(
  input wire logic         aclk,
  input wire logic         aresetn,
  input wire logic         internal_arbiter_disable_strap,
  input wire logic         scan_test_mode_n,
  input wire logic         scan_out_int,
  input wire logic         own_request,
  input wire bpm_sec_bus_t sec_bus,
  input wire logic [3:0]   secondary_grant_n,
  input wire logic         own_grant,
  input wire logic         sec_parked,
  input wire bpm_func_t    primary_func,
  input wire bpm_func_t    secondary_func,
  input wire bpm_pin_drv_t scan_led_pin
);
  logic [1:0] up_r;
  wire ext  = internal_arbiter_disable_strap;
  wire idle = sec_bus.frame_n & sec_bus.irdy_n;
  wire park = ext & ~sec_bus.req_n[0] & idle & ~own_request;
  // straps settle over two edges; up_r holds checks off for three edges after reset
  always_ff @(posedge aclk)
    up_r <= !aresetn ? 2'h0 : up_r + {1'h0, up_r != 2'h3};
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_live; up_r == 2'h3; endsequence
  sequence s_ext; up_r == 2'h3 && ext; endsequence
  sequence s_int; up_r == 2'h3 && !ext; endsequence
  ////////////////////////////////////////
  func_same_a: assert property (
    s_live |-> primary_func == secondary_func) else $error("funcs differ");
  one_grant_a: assert property (
    $onehot0(~secondary_grant_n)) else $error("two grants");
  ext_req_a: assert property (
    s_ext |-> secondary_grant_n[0] == !$past(own_request)) else $error("req");
  ext_quiet_a: assert property (
    s_ext |-> secondary_grant_n[3:1] == 3'h7) else $error("ext grant");
  ext_gnt_a: assert property (
    s_ext |-> own_grant == !$past(sec_bus.req_n[0])) else $error("gnt in");
  park_set_a: assert property (
    s_live ##0 park |=> sec_parked) else $error("no park");
  park_clr_a: assert property (
    s_live ##0 !park |=> !sec_parked) else $error("bad park");
  grant_cause_a: assert property (
    s_int |-> (~secondary_grant_n & $past(secondary_grant_n)
      & $past(sec_bus.req_n, 2)) == 4'h0) else $error("grant w/o req");
  led_drive_a: assert property (
    s_live ##0 scan_test_mode_n |-> !scan_led_pin.oe_n) else $error("led");
  scan_path_a: assert property (
    s_live ##0 !scan_test_mode_n |-> scan_led_pin.o == $past(scan_out_int))
    else $error("scan");
endmodule : bpm_strap_mux_asserts
bind bpm_strap_mux bpm_strap_mux_asserts u_chk (.*);
`default_nettype wire

// *** tb/bpm_ext_arb.sv ***
// external secondary arbiter and its grant to the bridge
// assumes the bench routes it only while the arbiter strap is high
`timescale 1ns/1ns
`default_nettype none
module bpm_ext_arb (
  input  wire logic aclk,
  input  wire logic bridge_req_n,
  input  wire logic park,
  input  wire logic hold,
  output var  logic bridge_gnt_n
);
  // hold models a slow arbiter busy with other masters
  always_ff @(posedge aclk)
    bridge_gnt_n <= hold | (bridge_req_n & ~park);
endmodule : bpm_ext_arb
`default_nettype wire

// *** tb/bridge_strap_and_pin_function_select_tb.sv ***
// self-checking bench for the strap and pin-function select block
// assumes bpm_pkg compiled first and bpm_defines.svh on the include path
`timescale 1ns/1ns
`default_nettype none
`include "bpm_defines.svh"
module bridge_strap_and_pin_function_select_tb import bpm_pkg::*;;
  logic aclk = 1'h0, aresetn = 1'h0, frame_n = 1'h1, irdy_n = 1'h1;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf, secondary_grant_n, req_n = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, arb_gnt_n;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, own_grant, sec_parked, park = 1'h0, hold = 1'h0;
  logic mode_select_lo = 1'h0, mode_shared_pin = 1'h0, own_request = 1'h0;
  logic internal_arbiter_disable_strap = 1'h0, scan_test_mode_n = 1'h1;
  logic scan_out_int = 1'h0;
  bpm_func_t primary_func, secondary_func;
  bpm_pin_drv_t scan_led_pin;
  bpm_sec_bus_t sec_bus;
  int err_total = 0, tests_run = 0, cyc = 0;
  assign sec_bus = {req_n[3:1], internal_arbiter_disable_strap ?
                    arb_gnt_n : req_n[0], frame_n, irdy_n};
  bpm_strap_mux u_dut (.*);
  bpm_ext_arb u_arb (.aclk, .bridge_req_n(secondary_grant_n[0]), .park,
                     .hold, .bridge_gnt_n(arb_gnt_n));
  always #50 aclk = ~aclk;
  ////////////////////////////////////////
  task automatic wrap_up();
    if (err_total == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic axi(input logic we, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic [1:0] r);
    logic done;
    done = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{we}};
    {s_axi_arvalid, s_axi_rready} <= {2{!we}};
    // each channel judged on the rising edge, pre-update values
    while (!done) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      done = we ? s_axi_bvalid : s_axi_rvalid;
    end
    q = s_axi_rdata;
    r = we ? s_axi_bresp : s_axi_rresp;
    {s_axi_bready, s_axi_rready} <= 2'h0;
  endtask : axi
  task automatic rst(input logic lo, pn, ds, sc);
    @(posedge aclk);
    aresetn <= 1'h0;
    {mode_select_lo, mode_shared_pin} <= {lo, pn};
    {internal_arbiter_disable_strap, scan_test_mode_n} <= {ds, sc};
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (4) @(posedge aclk);
  endtask : rst
  task automatic wgnt(input logic [3:0] e);
    int n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (secondary_grant_n !== e && n < 20);
    chk(secondary_grant_n, e);
  endtask : wgnt
  ////////////////////////////////////////
  task automatic t_modes();
    bpm_func_t fx [3] = '{BPM_FN_CLKRUN, BPM_FN_HOTSWP, BPM_FN_LOCK};
    logic [1:0] st [3] = '{2'h0, 2'h1, 2'h3};
    logic [31:0] q;
    logic [1:0] r;
    for (int i = 0; i < 3; i++) begin
      rst(st[i][1], st[i][0], 1'h0, 1'h1);
      @(negedge aclk);
      chk(primary_func, fx[i]);
      chk(secondary_func, fx[i]);
      axi(1'h0, `BPM_ADDR_STRAP, 32'h0000_0000, q, r);
      chk(q, {27'h0, 2'h2, &st[i], !st[i][1] & st[i][0], st[i][1]});
    end
  endtask : t_modes
  task automatic t_regs();
    logic [31:0] q;
    logic [1:0] r;
    axi(1'h1, `BPM_ADDR_FUNCTAB, 32'h0000_001b, q, r);
    chk(r, `BPM_AXI_OKAY);
    axi(1'h0, `BPM_ADDR_FUNCTAB, 32'h0000_0000, q, r);
    chk(q, 32'h0000_001b);
    @(negedge aclk);
    chk(primary_func, BPM_FN_HOTSWP);
    axi(1'h0, 12'h020, 32'h0000_0000, q, r);
    chk(r, `BPM_AXI_SLVERR);
    axi(1'h1, `BPM_ADDR_STRAP, 32'h0000_0000, q, r);
    chk(r, `BPM_AXI_SLVERR);
  endtask : t_regs
  task automatic t_led();
    logic [31:0] q;
    logic [1:0] r;
    axi(1'h1, `BPM_ADDR_LED, 32'h0000_0001, q, r);
    repeat (2) @(negedge aclk);
    chk(scan_led_pin, 2'h2);
    rst(1'h0, 1'h0, 1'h0, 1'h0);
    for (int i = 0; i < 2; i++) begin
      @(posedge aclk);
      scan_out_int <= !i[0];
      repeat (2) @(negedge aclk);
      chk(scan_led_pin.o, !i[0]);
    end
  endtask : t_led
  task automatic t_int();
    logic [31:0] q;
    logic [1:0] r;
    rst(1'h0, 1'h0, 1'h0, 1'h1);
    req_n <= 4'hd;
    wgnt(4'hd);
    @(posedge aclk);
    {req_n, frame_n} <= {4'hf, 1'h0};
    @(posedge aclk);
    frame_n <= 1'h1;
    wgnt(4'hf);
    // low rotation alone would pick 2; high group must win with 1
    axi(1'h1, `BPM_ADDR_PRIO, 32'h0000_0002, q, r);
    req_n <= 4'h9;
    wgnt(4'hd);
  endtask : t_int
  task automatic t_ext();
    logic [31:0] q;
    logic [1:0] r;
    rst(1'h0, 1'h0, 1'h1, 1'h1);
    own_request <= 1'h1;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    chk(secondary_grant_n, 4'he);
    chk(own_grant, 1'h1);
    @(posedge aclk);
    {own_request, park} <= 2'h1;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    chk(sec_parked, 1'h1);
    axi(1'h0, `BPM_ADDR_ARB, 32'h0000_0000, q, r);
    chk(q, 32'h0000_00fc);
    @(posedge aclk);
    hold <= 1'h1;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    chk({own_grant, sec_parked}, 2'h0);
  endtask : t_ext
  initial begin
    t_modes();
    t_regs();
    t_led();
    t_int();
    t_ext();
    wrap_up();
  end
endmodule : bridge_strap_and_pin_function_select_tb
`default_nettype wire
